// ### hw/cmp_pkg.sv
// Shared constants for the dual comparator control block
package cmp_pkg;
  // Register offsets (word index on the plain register port)
  localparam logic [3:0] UNIT1_CTRL_OFS   = 4'h0;
  localparam logic [3:0] UNIT2_CTRL_OFS   = 4'h1;
  localparam logic [3:0] SHARED_CTRL_OFS  = 4'h2;
  localparam logic [3:0] FLAG_REG_OFS     = 4'h3;
  localparam logic [3:0] ENABLE_REG_OFS   = 4'h4;
  localparam logic [3:0] GLOBAL_REG_OFS   = 4'h5;

  // Unit control register fields
  localparam int ON_POS     = 7;
  localparam int RESULT_POS = 6;
  localparam int DRIVE_POS  = 5;
  localparam int INV_POS    = 4;
  localparam int SPEED_POS  = 3;
  localparam int PSRC_POS   = 2;
  localparam int CHAN_LSB   = 0;

  // Shared control register fields
  localparam int MIR1_POS   = 7;
  localparam int MIR2_POS   = 6;
  localparam int RSEL1_POS  = 5;
  localparam int RSEL2_POS  = 4;
  localparam int SYNC1_POS  = 1;
  localparam int SYNC2_POS  = 0;

  // Global enable register fields
  localparam int GIE_POS    = 1;
  localparam int PEIE_POS   = 0;

  // Reset values
  localparam logic [7:0] UNIT_CTRL_RST   = 8'h08;
  localparam logic [7:0] SHARED_CTRL_RST = 8'h00;

  // Instruction cycle is four core clocks: phase one and phase three
  localparam logic [1:0] PHASE_ONE   = 2'h0;
  localparam logic [1:0] PHASE_THREE = 2'h2;
endpackage : cmp_pkg

// ### hw/dual_comparator_control.sv
// Control, change detection and flags for two comparator units
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module dual_comparator_control
  import cmp_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdData,
  input  wire logic [1:0] rawCompare,
  input  wire logic [1:0] pinDirectionBit,
  input  wire logic [1:0] portDataLatch,
  input  wire logic       sleepMode,
  input  wire logic       timerClk,
  output logic      [1:0] compPinOut,
  output logic      [1:0] compPinOe,
  output logic      [1:0] unitPowerOn,
  output logic      [1:0] lowPowerMode,
  output logic      [3:0] negativeChannelSelect,
  output logic      [1:0] positiveSourceSelect,
  output logic      [1:0] refSelect,
  output logic      [1:0] resultToTimer,
  output logic      [1:0] resultInternal,
  output logic            irqRequest
);

  typedef struct packed {
    logic [1:0][7:0] unitCtrl;
    logic [7:0]      sharedCtrl;
    logic [1:0]      flag;
    logic [1:0]      irqEn;
    logic            gie;
    logic            peie;
    logic [1:0]      phase;
    logic [1:0]      firstLatch;
    logic [1:0]      secondLatch;
    logic [1:0]      mismatchPrev;
    logic [1:0]      rawMeta;
    logic [1:0]      rawSync;
    logic [1:0]      tclkMeta;
    logic            tclkPrev;
    logic [1:0]      syncResult;
    logic [7:0]      rdData;
  } state_t;

  state_t stateQ;
  state_t stateD;

  logic [1:0] gatedRaw;
  logic [1:0] polResult;
  logic [1:0] ctrlAccess;
  logic [1:0] mismatch;
  logic       tclkFall;

  // Raw compare arrives from analog, so pass it through two flops first
  // Gated result and polarity stage
  always_comb begin
    for (int u = 0; u < 2; u++) begin
      // Analog result is high when positive input exceeds negative
      gatedRaw[u]  = stateQ.rawSync[u] & stateQ.unitCtrl[u][ON_POS];
      polResult[u] = gatedRaw[u] ^ stateQ.unitCtrl[u][INV_POS];
    end
  end

  // One strobe per unit control access, read or write
  assign ctrlAccess[0] = (regRead | regWrite) && (regAddr == UNIT1_CTRL_OFS);
  assign ctrlAccess[1] = (regRead | regWrite) && (regAddr == UNIT2_CTRL_OFS);
  assign mismatch      = stateQ.firstLatch ^ stateQ.secondLatch;
  // Timer clock is a pin, only its second sync flop is looked at
  assign tclkFall      = stateQ.tclkPrev & ~stateQ.tclkMeta[1];

  // Next-state logic
  always_comb begin
    stateD = stateQ;
    stateD.phase = stateQ.phase + 2'h1;
    stateD.rawMeta  = rawCompare;
    stateD.rawSync  = stateQ.rawMeta;
    stateD.tclkMeta = {stateQ.tclkMeta[0], timerClk};
    stateD.tclkPrev = stateQ.tclkMeta[1];
    stateD.mismatchPrev = mismatch;

    // Second latch at phase one; held open in sleep
    if (stateQ.phase == PHASE_ONE || sleepMode) begin
      stateD.secondLatch = polResult;
    end

    // Result for timer gating, latched on every falling timer edge; used when asked
    for (int u = 0; u < 2; u++) begin
      if (tclkFall) begin
        stateD.syncResult[u] = polResult[u];
      end
    end

    // First latch: any unit control access; write implies read
    // Access strobe is a single cycle, so capture at that cycle stands for phase three
    for (int u = 0; u < 2; u++) begin
      if (ctrlAccess[u]) begin
        stateD.firstLatch[u] = polResult[u];
      end
    end

    // Flag on mismatch rising edge; independent of drive enable
    for (int u = 0; u < 2; u++) begin
      if (regWrite && regAddr == FLAG_REG_OFS) begin
        stateD.flag[u] = regWrData[u];
      end
      if (mismatch[u] && !stateQ.mismatchPrev[u]) begin
        stateD.flag[u] = 1'b1;
      end
    end

    // Register writes
    if (regWrite) begin
      if (regAddr == UNIT1_CTRL_OFS) begin
        stateD.unitCtrl[0] = regWrData & ~(8'h01 << RESULT_POS);
      end else if (regAddr == UNIT2_CTRL_OFS) begin
        stateD.unitCtrl[1] = regWrData & ~(8'h01 << RESULT_POS);
      end else if (regAddr == SHARED_CTRL_OFS) begin
        stateD.sharedCtrl = regWrData & 8'h33;
      end else if (regAddr == ENABLE_REG_OFS) begin
        stateD.irqEn = regWrData[1:0];
      end else if (regAddr == GLOBAL_REG_OFS) begin
        stateD.gie  = regWrData[GIE_POS];
        stateD.peie = regWrData[PEIE_POS];
      end
    end

    // Read data, one cycle later; shared read leaves latches alone
    stateD.rdData = 8'h00;
    if (regRead) begin
      if (regAddr == UNIT1_CTRL_OFS) begin
        stateD.rdData = stateQ.unitCtrl[0] | ({7'h00, stateQ.secondLatch[0]} << RESULT_POS);
      end else if (regAddr == UNIT2_CTRL_OFS) begin
        stateD.rdData = stateQ.unitCtrl[1] | ({7'h00, stateQ.secondLatch[1]} << RESULT_POS);
      end else if (regAddr == SHARED_CTRL_OFS) begin
        stateD.rdData = stateQ.sharedCtrl
                      | ({7'h00, stateQ.secondLatch[0]} << MIR1_POS)
                      | ({7'h00, stateQ.secondLatch[1]} << MIR2_POS);
      end else if (regAddr == FLAG_REG_OFS) begin
        stateD.rdData = {6'h00, stateQ.flag};
      end else if (regAddr == ENABLE_REG_OFS) begin
        stateD.rdData = {6'h00, stateQ.irqEn};
      end else if (regAddr == GLOBAL_REG_OFS) begin
        stateD.rdData = {6'h00, stateQ.gie, stateQ.peie};
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stateQ <= '0;
      stateQ.unitCtrl[0] <= UNIT_CTRL_RST;
      stateQ.unitCtrl[1] <= UNIT_CTRL_RST;
      stateQ.sharedCtrl  <= SHARED_CTRL_RST;
    end else begin
      stateQ <= stateD;
    end
  end

  // Outputs: pin path unlatched, straight from the polarity stage
  always_comb begin
    for (int u = 0; u < 2; u++) begin
      // Undriven pin keeps showing the port latch, so input pins see no override
      compPinOut[u] = (stateQ.unitCtrl[u][DRIVE_POS] & ~pinDirectionBit[u])
                    ? (polResult[u] & stateQ.unitCtrl[u][ON_POS])
                    : portDataLatch[u];
      compPinOe[u]  = ~(stateQ.unitCtrl[u][DRIVE_POS] & ~pinDirectionBit[u]);
      unitPowerOn[u]  = stateQ.unitCtrl[u][ON_POS];
      lowPowerMode[u] = ~stateQ.unitCtrl[u][SPEED_POS];
      negativeChannelSelect[2*u +: 2] = stateQ.unitCtrl[u][CHAN_LSB +: 2];
      positiveSourceSelect[u] = stateQ.unitCtrl[u][PSRC_POS];
      resultInternal[u] = stateQ.secondLatch[u];
    end
    refSelect        = {stateQ.sharedCtrl[RSEL2_POS], stateQ.sharedCtrl[RSEL1_POS]};
    resultToTimer[0] = stateQ.sharedCtrl[SYNC1_POS] ? stateQ.syncResult[0] : polResult[0];
    resultToTimer[1] = stateQ.sharedCtrl[SYNC2_POS] ? stateQ.syncResult[1] : polResult[1];
    irqRequest = |(stateQ.flag & stateQ.irqEn) & stateQ.peie & stateQ.gie;
  end

  assign regRdData = stateQ.rdData;

endmodule : dual_comparator_control

// ### tb/dual_comparator_control_chk.sv
// Port-level property checker for the dual comparator control block
`timescale 1ns/1ps
module dual_comparator_control_chk
  import cmp_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdData,
  input wire logic [1:0] pinDirectionBit,
  input wire logic [1:0] portDataLatch,
  input wire logic       sleepMode,
  input wire logic [1:0] compPinOut,
  input wire logic [1:0] compPinOe,
  input wire logic [1:0] unitPowerOn,
  input wire logic [1:0] lowPowerMode,
  input wire logic [3:0] negativeChannelSelect,
  input wire logic [1:0] resultInternal
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Write to the first unit's control word
  sequence wr1;
    regWrite && regAddr == UNIT1_CTRL_OFS;
  endsequence
  // A capture seen while awake; the next one is a full cycle away
  sequence awake_capture;
    (!sleepMode)[*2] ##1 (!sleepMode && $changed(resultInternal));
  endsequence
  rd_idle_a: assert property (!$past(regRead) |-> regRdData == 8'h00)
    else $error("read data outside read slot");
  oe_input_a: assert property (pinDirectionBit[0] |-> compPinOe[0])
    else $error("pin driven while set as input");
  pin_latch_a: assert property (compPinOe[0] |-> compPinOut[0] == portDataLatch[0])
    else $error("port latch not passed through");
  chan_write_a: assert property (wr1 |=> negativeChannelSelect[1:0] == $past(regWrData[1:0]))
    else $error("channel select not written");
  on_write_a: assert property (wr1 |=> unitPowerOn[0] == $past(regWrData[ON_POS]))
    else $error("on bit not written");
  speed_write_a: assert property (wr1 |=> lowPowerMode[0] == !$past(regWrData[SPEED_POS]))
    else $error("speed select not written");
  cfg_hold_a: assert property (!$past(regWrite) |-> $stable({negativeChannelSelect, unitPowerOn}))
    else $error("config moved without a write");
  capture_rate_a: assert property (awake_capture |=> $stable(resultInternal) || sleepMode)
    else $error("result captured twice in one cycle");
endmodule : dual_comparator_control_chk

bind dual_comparator_control dual_comparator_control_chk chk_inst (.*);

// ### tb/comp_front_model.sv
// Analog front model: input relations become raw comparator levels
`timescale 1ns/1ps
module comp_front_model (
  input  wire logic [1:0] posAbove,
  output logic      [1:0] rawCompare
);
  // High when the positive input sits above the negative one
  assign rawCompare = posAbove;
endmodule : comp_front_model

// ### tb/dual_comparator_control_bench.sv
// Self-checking bench for the dual comparator control block
`timescale 1ns/1ps
module dual_comparator_control_bench;
  import cmp_pkg::*;
  logic       core_clk, resetn, regWrite, regRead, sleepMode, timerClk, irqRequest, r;
  logic [3:0] regAddr, negativeChannelSelect;
  logic [7:0] regWrData, regRdData, cfg;
  logic [1:0] posAbove, rawCompare, pinDirectionBit, portDataLatch, compPinOut, compPinOe;
  logic [1:0] unitPowerOn, lowPowerMode, positiveSourceSelect, refSelect;
  logic [1:0] resultToTimer, resultInternal;
  int         miscompares, cmp_count;
  dual_comparator_control dual_comparator_control_inst (.*);
  comp_front_model comp_front_model_inst (.posAbove(posAbove), .rawCompare(rawCompare));
  function automatic logic res_exp(input logic [7:0] c, input logic raw);
    return (c[ON_POS] & raw) ^ c[INV_POS]; // Off unit feeds zero to the inverter
  endfunction : res_exp
  task automatic chk(input logic [7:0] got, input logic [7:0] e);
    cmp_count++;
    if (got !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge core_clk);
    regWrite  <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 chk(regRdData, e);
    @(posedge core_clk);
  endtask : rd_chk
  // Sync flops, a full capture cycle and the flag stage all fit in ten clocks
  task automatic step(input logic [1:0] p, input logic [7:0] f);
    posAbove <= p;
    repeat (10) @(posedge core_clk);
    rd_chk(FLAG_REG_OFS, f);
  endtask : step
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Cut a hang short well past the expected run
  initial begin
    #100us;
    miscompares++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'had41));
    resetn = 1'b0;
    {regWrite, regRead, sleepMode, timerClk, regAddr, regWrData, posAbove} = '0;
    {pinDirectionBit, portDataLatch} = 4'hc;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    rd_chk(UNIT1_CTRL_OFS, UNIT_CTRL_RST);
    rd_chk(UNIT2_CTRL_OFS, UNIT_CTRL_RST);
    rd_chk(SHARED_CTRL_OFS, SHARED_CTRL_RST);
    rd_chk(4'hf, 8'h00);
    // Mirror and reserved bits refuse writes; reference selects land
    wr(SHARED_CTRL_OFS, 8'hff);
    rd_chk(SHARED_CTRL_OFS, 8'h33);
    chk({6'h0, refSelect}, 8'h03);
    wr(SHARED_CTRL_OFS, 8'h00);
    chk({6'h0, compPinOe}, 8'h03);
    // Change detection on unit one; enable glitches flushed first
    wr(UNIT1_CTRL_OFS, 8'h88);
    step(2'h0, 8'h00);
    step(2'h1, 8'h01);
    wr(FLAG_REG_OFS, 8'h00);
    step(2'h0, 8'h00);
    step(2'h1, 8'h01);
    rd_chk(UNIT1_CTRL_OFS, 8'hc8);
    wr(FLAG_REG_OFS, 8'h00);
    step(2'h0, 8'h01);
    wr(UNIT1_CTRL_OFS, 8'h88);
    wr(FLAG_REG_OFS, 8'h00);
    step(2'h1, 8'h01);
    wr(FLAG_REG_OFS, 8'h00);
    rd_chk(SHARED_CTRL_OFS, 8'h80);
    step(2'h0, 8'h00);
    // Software set of a flag, then every combination of the unit two enable and both global enables
    wr(FLAG_REG_OFS, 8'h02);
    rd_chk(FLAG_REG_OFS, 8'h02);
    for (int i = 0; i < 8; i++) begin
      wr(ENABLE_REG_OFS, {6'h0, i[2], 1'b0});
      wr(GLOBAL_REG_OFS, {6'h0, i[1:0]});
      #1 chk({7'h0, irqRequest}, {7'h0, i == 7});
      @(posedge core_clk);
    end
    // Random unit two settings against random inputs and pin wiring
    repeat (24) begin
      cfg = 8'($urandom) & 8'hbf;
      {posAbove, pinDirectionBit, portDataLatch, sleepMode, timerClk} <= 8'($urandom);
      wr(UNIT2_CTRL_OFS, cfg);
      repeat (10) @(posedge core_clk);
      #1 r = res_exp(cfg, posAbove[1]);
      chk({negativeChannelSelect[3:2], positiveSourceSelect[1], unitPowerOn[1], lowPowerMode[1],
           compPinOe[1], 2'h0}, {cfg[1:0], cfg[PSRC_POS], cfg[ON_POS], !cfg[SPEED_POS],
           !(cfg[DRIVE_POS] && !pinDirectionBit[1]), 2'h0});
      if (compPinOe[1] === 1'b1 || cfg[ON_POS])
        chk({7'h0, compPinOut[1]}, {7'h0, compPinOe[1] ? portDataLatch[1] : r});
      chk({7'h0, resultToTimer[1]}, {7'h0, r});
      @(posedge core_clk);
      rd_chk(UNIT2_CTRL_OFS, cfg | {1'b0, r, 6'h0});
    end
    give_verdict();
  end
endmodule : dual_comparator_control_bench
